// [pkg/usb_host_regs_pkg.sv]
package usb_host_regs_pkg;

   // Base of the register window in the CPU memory map
   localparam logic [31:0] BASE_ADDR      = 32'h1000b000;
   localparam logic [31:0] WINDOW_MASK    = 32'hffffff00;

   // Register byte offsets
   localparam logic [7:0] OFS_SPEC_VERSION  = 8'h00;
   localparam logic [7:0] OFS_HOST_STATE    = 8'h04;
   localparam logic [7:0] OFS_COMMAND       = 8'h08;
   localparam logic [7:0] OFS_IRQ_FLAGS     = 8'h0c;
   localparam logic [7:0] OFS_IRQ_EN_SET    = 8'h10;
   localparam logic [7:0] OFS_IRQ_EN_CLR    = 8'h14;
   localparam logic [7:0] OFS_COMM_AREA     = 8'h18;
   localparam logic [7:0] OFS_PERIODIC_CUR  = 8'h1c;
   localparam logic [7:0] OFS_CTRL_HEAD     = 8'h20;
   localparam logic [7:0] OFS_CTRL_CUR      = 8'h24;
   localparam logic [7:0] OFS_BULK_HEAD     = 8'h28;
   localparam logic [7:0] OFS_BULK_CUR      = 8'h2c;
   localparam logic [7:0] OFS_DONE_HEAD     = 8'h30;
   localparam logic [7:0] OFS_FRAME_LENGTH  = 8'h34;
   localparam logic [7:0] OFS_FRAME_LEFT    = 8'h38;
   localparam logic [7:0] OFS_FRAME_COUNT   = 8'h3c;
   localparam logic [7:0] OFS_PERIODIC_BEG  = 8'h40;
   localparam logic [7:0] OFS_SLOW_LIMIT    = 8'h44;
   localparam logic [7:0] OFS_HUB_DESC_A    = 8'h48;
   localparam logic [7:0] OFS_HUB_DESC_B    = 8'h4c;
   localparam logic [7:0] OFS_HUB_GLOBAL    = 8'h50;
   localparam logic [7:0] OFS_HUB_PORT1     = 8'h54;
   localparam logic [7:0] OFS_HUB_PORT2     = 8'h58;

   // Revision value (1.0)
   localparam logic [7:0] SPEC_VERSION      = 8'h10;

   // Control register fields
   localparam int CTL_RATIO_LSB    = 0;
   localparam int CTL_PERIODIC_BIT = 2;
   localparam int CTL_ISO_BIT      = 3;
   localparam int CTL_CTRL_BIT     = 4;
   localparam int CTL_BULK_BIT     = 5;
   localparam int CTL_STATE_LSB    = 6;
   localparam int CTL_ROUTE_BIT    = 8;

   // Command/status fields
   localparam int CMD_RESET_BIT    = 0;
   localparam int CMD_CTRL_BIT     = 1;
   localparam int CMD_BULK_BIT     = 2;
   localparam int CMD_OWNER_BIT    = 3;
   localparam int CMD_OVR_LSB      = 16;

   // Interrupt flag / enable positions
   localparam int IRQ_OVERRUN_BIT  = 0;
   localparam int IRQ_DONE_BIT     = 1;
   localparam int IRQ_SOF_BIT      = 2;
   localparam int IRQ_RESUME_BIT   = 3;
   localparam int IRQ_FATAL_BIT    = 4;
   localparam int IRQ_WRAP_BIT     = 5;
   localparam int IRQ_HUB_BIT      = 6;
   localparam int IRQ_OWNER_BIT    = 30;
   localparam int IRQ_GATE_BIT     = 31;
   localparam logic [31:0] IRQ_SRC_MASK = 32'h4000006f;

   // Pointer masks
   localparam logic [31:0] COMM_AREA_MASK = 32'hffffff00;
   localparam logic [31:0] LIST_PTR_MASK  = 32'hfffffff0;

   // Reset values
   localparam logic [31:0] RST_WORD       = 32'h00000000;

   typedef enum logic [1:0]
   {
      state_reset,
      state_resume,
      state_operational,
      state_suspend
   } func_state_t;

endpackage

// [hdl/usb_host_operational_regs.sv]
`timescale 1ns/1ps
`default_nettype none

module usb_host_operational_regs
(
   input  wire logic                                    clk,
   input  wire logic                                    arst_n,
   input  wire logic                                    ce,
   input  wire logic                                    bus_sel,
   input  wire logic                                    bus_wr,
   input  wire logic [31:0]                             bus_addr,
   input  wire logic [31:0]                             bus_wdata,
   output logic      [31:0]                             bus_rdata,
   output logic                                         bus_ack,
   input  wire logic                                    resume_detect,
   input  wire logic                                    frame_begin_event,
   input  wire logic                                    done_written_event,
   input  wire logic                                    overrun_event,
   input  wire logic                                    hub_change_event,
   input  wire logic [15:0]                             frame_counter,
   input  wire logic                                    bulk_head_start,
   input  wire logic                                    ctrl_head_start,
   input  wire logic                                    bulk_fill_hw,
   input  wire logic                                    ctrl_fill_hw,
   input  wire logic                                    soft_reset_done,
   output usb_host_regs_pkg::func_state_t               functional_state_field,
   output logic      [1:0]                              ctrl_to_bulk_ratio,
   output logic                                         bulk_proc_en,
   output logic                                         ctrl_proc_en,
   output logic                                         frame_periodic_go,
   output logic                                         frame_iso_go,
   output logic                                         soft_reset_cmd,
   output logic                                         bulk_pending,
   output logic                                         ctrl_pending,
   output logic                                         irq_out,
   output logic                                         system_mgmt_irq,
   output logic      [31:0]                             shared_comm_area,
   output logic      [31:0]                             periodic_cur_ptr,
   output logic      [31:0]                             ctrl_head_ptr,
   output logic      [31:0]                             ctrl_cur_ptr,
   output logic      [31:0]                             bulk_head_ptr,
   output logic      [31:0]                             bulk_cur_ptr,
   output logic      [31:0]                             done_head_ptr
);
   import usb_host_regs_pkg::*;

   logic        rst_meta;
   logic        rst_n;
   logic        route_sel;
   logic        iso_proc_en;
   logic        periodic_proc_en;
   logic        owner_request;
   logic [1:0]  overrun_counter;
   logic [31:0] irq_flags;
   logic [31:0] irq_enables;
   logic        frame_msb_prev;
   logic        in_window;
   logic        wr_go;
   logic [31:0] next_rdata;
   logic [31:0] hw_events;
   logic        irq_pending;

   // Write strobe for one register offset
   function automatic logic wr_hit(input logic [31:0] addr, input logic [7:0] ofs,
                                   input logic go);
      wr_hit = go && (addr[7:0] == ofs);
   endfunction

   // Reset release through two flip-flops
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         rst_meta <= 1'b0;
         rst_n    <= 1'b0;
      end
      else
      begin
         rst_meta <= 1'b1;
         rst_n    <= rst_meta;
      end
   end

   // Decode of the fixed memory window, word aligned; a request held over its ack is not retaken
   assign in_window = ((bus_addr & WINDOW_MASK) == BASE_ADDR) && (bus_addr[1:0] == 2'b00);
   assign wr_go     = bus_sel && bus_wr && in_window && ce && !bus_ack;

   // Hardware event vector feeding the flags
   always_comb
   begin
      hw_events                  = 32'h00000000;
      hw_events[IRQ_OVERRUN_BIT] = overrun_event;
      hw_events[IRQ_DONE_BIT]    = done_written_event;
      hw_events[IRQ_SOF_BIT]     = frame_begin_event;
      hw_events[IRQ_RESUME_BIT]  = resume_detect;
      hw_events[IRQ_WRAP_BIT]    = frame_counter[15] ^ frame_msb_prev;
      hw_events[IRQ_HUB_BIT]     = hub_change_event;
      hw_events[IRQ_OWNER_BIT]   = wr_hit(bus_addr, OFS_COMMAND, wr_go)
                                   && bus_wdata[CMD_OWNER_BIT];
   end

   // Control register fields and functional state
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         functional_state_field <= state_reset;
         route_sel              <= 1'b0;
         ctrl_to_bulk_ratio     <= 2'b00;
         bulk_proc_en           <= 1'b0;
         ctrl_proc_en           <= 1'b0;
         iso_proc_en            <= 1'b0;
         periodic_proc_en       <= 1'b0;
      end
      else if (!rst_n)
      begin
         functional_state_field <= state_reset;
         route_sel              <= 1'b0;
         ctrl_to_bulk_ratio     <= 2'b00;
         bulk_proc_en           <= 1'b0;
         ctrl_proc_en           <= 1'b0;
         iso_proc_en            <= 1'b0;
         periodic_proc_en       <= 1'b0;
      end
      else if (ce)
      begin
         if (wr_hit(bus_addr, OFS_HOST_STATE, wr_go))
         begin
            functional_state_field <= func_state_t'(bus_wdata[CTL_STATE_LSB +: 2]);
            route_sel              <= bus_wdata[CTL_ROUTE_BIT];
            ctrl_to_bulk_ratio     <= bus_wdata[CTL_RATIO_LSB +: 2];
            bulk_proc_en           <= bus_wdata[CTL_BULK_BIT];
            ctrl_proc_en           <= bus_wdata[CTL_CTRL_BIT];
            iso_proc_en            <= bus_wdata[CTL_ISO_BIT];
            periodic_proc_en       <= bus_wdata[CTL_PERIODIC_BIT];
         end
         else if (resume_detect && functional_state_field == state_suspend)
         begin
            functional_state_field <= state_resume;
         end
      end
   end

   // Periodic gates latched at each frame start for the list walker
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         frame_periodic_go <= 1'b0;
         frame_iso_go      <= 1'b0;
      end
      else if (!rst_n)
      begin
         frame_periodic_go <= 1'b0;
         frame_iso_go      <= 1'b0;
      end
      else if (ce && frame_begin_event)
      begin
         frame_periodic_go <= periodic_proc_en;
         frame_iso_go      <= periodic_proc_en && iso_proc_en;
      end
   end

   // Command/status: reset command, filled bits, ownership request, overrun count
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         soft_reset_cmd  <= 1'b0;
         bulk_pending    <= 1'b0;
         ctrl_pending    <= 1'b0;
         owner_request   <= 1'b0;
         overrun_counter <= 2'b00;
      end
      else if (!rst_n)
      begin
         soft_reset_cmd  <= 1'b0;
         bulk_pending    <= 1'b0;
         ctrl_pending    <= 1'b0;
         owner_request   <= 1'b0;
         overrun_counter <= 2'b00;
      end
      else if (ce)
      begin
         if (wr_hit(bus_addr, OFS_COMMAND, wr_go))
         begin
            owner_request <= bus_wdata[CMD_OWNER_BIT];
         end
         // A software set beats a same-cycle completion
         if (wr_hit(bus_addr, OFS_COMMAND, wr_go) && bus_wdata[CMD_RESET_BIT])
            soft_reset_cmd <= 1'b1;
         else if (soft_reset_done)
            soft_reset_cmd <= 1'b0;
         if ((wr_hit(bus_addr, OFS_COMMAND, wr_go) && bus_wdata[CMD_BULK_BIT]) || bulk_fill_hw)
            bulk_pending <= 1'b1;
         else if (bulk_head_start)
            bulk_pending <= 1'b0;
         if ((wr_hit(bus_addr, OFS_COMMAND, wr_go) && bus_wdata[CMD_CTRL_BIT]) || ctrl_fill_hw)
            ctrl_pending <= 1'b1;
         else if (ctrl_head_start)
            ctrl_pending <= 1'b0;
         if (overrun_event)
            overrun_counter <= overrun_counter + 2'b01;
      end
   end

   // Sticky flags: hardware sets, software writes one to clear, set wins
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         irq_flags      <= RST_WORD;
         frame_msb_prev <= 1'b0;
      end
      else if (!rst_n)
      begin
         irq_flags      <= RST_WORD;
         frame_msb_prev <= frame_counter[15];
      end
      else if (ce)
      begin
         frame_msb_prev <= frame_counter[15];
         if (wr_hit(bus_addr, OFS_IRQ_FLAGS, wr_go))
            irq_flags <= ((irq_flags & ~bus_wdata) | hw_events) & IRQ_SRC_MASK;
         else
            irq_flags <= (irq_flags | hw_events) & IRQ_SRC_MASK;
      end
   end

   // Enable state shared by the set and clear views
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
         irq_enables <= RST_WORD;
      else if (!rst_n)
         irq_enables <= RST_WORD;
      else if (ce)
      begin
         if (wr_hit(bus_addr, OFS_IRQ_EN_SET, wr_go))
            irq_enables <= (irq_enables | bus_wdata)
                           & (IRQ_SRC_MASK | (32'h1 << IRQ_GATE_BIT));
         else if (wr_hit(bus_addr, OFS_IRQ_EN_CLR, wr_go))
            irq_enables <= irq_enables & ~bus_wdata;
      end
   end

   // Memory pointers; unused low bits are never stored
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         shared_comm_area <= RST_WORD;
         periodic_cur_ptr <= RST_WORD;
         ctrl_head_ptr    <= RST_WORD;
         ctrl_cur_ptr     <= RST_WORD;
         bulk_head_ptr    <= RST_WORD;
         bulk_cur_ptr     <= RST_WORD;
         done_head_ptr    <= RST_WORD;
      end
      else if (!rst_n)
      begin
         shared_comm_area <= RST_WORD;
         periodic_cur_ptr <= RST_WORD;
         ctrl_head_ptr    <= RST_WORD;
         ctrl_cur_ptr     <= RST_WORD;
         bulk_head_ptr    <= RST_WORD;
         bulk_cur_ptr     <= RST_WORD;
         done_head_ptr    <= RST_WORD;
      end
      else if (ce)
      begin
         if (wr_hit(bus_addr, OFS_COMM_AREA, wr_go))
            shared_comm_area <= bus_wdata & COMM_AREA_MASK;
         if (wr_hit(bus_addr, OFS_PERIODIC_CUR, wr_go))
            periodic_cur_ptr <= bus_wdata & LIST_PTR_MASK;
         if (wr_hit(bus_addr, OFS_CTRL_HEAD, wr_go))
            ctrl_head_ptr <= bus_wdata & LIST_PTR_MASK;
         if (wr_hit(bus_addr, OFS_CTRL_CUR, wr_go))
            ctrl_cur_ptr <= bus_wdata & LIST_PTR_MASK;
         if (wr_hit(bus_addr, OFS_BULK_HEAD, wr_go))
            bulk_head_ptr <= bus_wdata & LIST_PTR_MASK;
         if (wr_hit(bus_addr, OFS_BULK_CUR, wr_go))
            bulk_cur_ptr <= bus_wdata & LIST_PTR_MASK;
         if (wr_hit(bus_addr, OFS_DONE_HEAD, wr_go))
            done_head_ptr <= bus_wdata & LIST_PTR_MASK;
      end
   end

   // Read data selection; frame and hub registers live in other blocks
   always_comb
   begin
      next_rdata = 32'h00000000;
      unique case (bus_addr[7:0])
         OFS_SPEC_VERSION: next_rdata[7:0] = SPEC_VERSION;
         OFS_HOST_STATE:
         begin
            next_rdata[CTL_RATIO_LSB +: 2]  = ctrl_to_bulk_ratio;
            next_rdata[CTL_PERIODIC_BIT]    = periodic_proc_en;
            next_rdata[CTL_ISO_BIT]         = iso_proc_en;
            next_rdata[CTL_CTRL_BIT]        = ctrl_proc_en;
            next_rdata[CTL_BULK_BIT]        = bulk_proc_en;
            next_rdata[CTL_STATE_LSB +: 2]  = functional_state_field;
            next_rdata[CTL_ROUTE_BIT]       = route_sel;
         end
         OFS_COMMAND:
         begin
            next_rdata[CMD_RESET_BIT]       = soft_reset_cmd;
            next_rdata[CMD_CTRL_BIT]        = ctrl_pending;
            next_rdata[CMD_BULK_BIT]        = bulk_pending;
            next_rdata[CMD_OWNER_BIT]       = owner_request;
            next_rdata[CMD_OVR_LSB +: 2]    = overrun_counter;
         end
         OFS_IRQ_FLAGS:    next_rdata = irq_flags;
         OFS_IRQ_EN_SET:   next_rdata = irq_enables;
         OFS_IRQ_EN_CLR:   next_rdata = irq_enables;
         OFS_COMM_AREA:    next_rdata = shared_comm_area;
         OFS_PERIODIC_CUR: next_rdata = periodic_cur_ptr;
         OFS_CTRL_HEAD:    next_rdata = ctrl_head_ptr;
         OFS_CTRL_CUR:     next_rdata = ctrl_cur_ptr;
         OFS_BULK_HEAD:    next_rdata = bulk_head_ptr;
         OFS_BULK_CUR:     next_rdata = bulk_cur_ptr;
         OFS_DONE_HEAD:    next_rdata = done_head_ptr;
         default:          next_rdata = 32'h00000000;
      endcase
   end

   // Bus answer one cycle after a selected access
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         bus_rdata <= 32'h00000000;
         bus_ack   <= 1'b0;
      end
      else if (!rst_n)
      begin
         bus_rdata <= 32'h00000000;
         bus_ack   <= 1'b0;
      end
      else if (ce)
      begin
         bus_ack   <= bus_sel && in_window && !bus_ack;
         bus_rdata <= (bus_sel && !bus_wr && in_window && !bus_ack) ? next_rdata : 32'h00000000;
      end
   end

   // Any enabled flag under the master gate
   assign irq_pending = irq_enables[IRQ_GATE_BIT] && |(irq_flags & irq_enables & IRQ_SRC_MASK);

   // Interrupt routed to one of two outputs
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         irq_out         <= 1'b0;
         system_mgmt_irq <= 1'b0;
      end
      else if (!rst_n)
      begin
         irq_out         <= 1'b0;
         system_mgmt_irq <= 1'b0;
      end
      else if (ce)
      begin
         irq_out         <= irq_pending && !route_sel;
         system_mgmt_irq <= irq_pending && route_sel;
      end
   end

endmodule

`default_nettype wire

// [verif/usb_host_regs_sva.sv]
`timescale 1ns/1ps
`default_nettype none
// Port-level checks of the register bank
module usb_host_regs_sva
(
   input wire logic                           clk,
   input wire logic                           arst_n,
   input wire logic                           ce,
   input wire logic                           bus_sel,
   input wire logic                           bus_wr,
   input wire logic [31:0]                    bus_addr,
   input wire logic [31:0]                    bus_rdata,
   input wire logic                           bus_ack,
   input wire logic                           resume_detect,
   input wire logic                           frame_begin_event,
   input wire logic                           ctrl_head_start,
   input wire logic                           ctrl_fill_hw,
   input wire logic                           soft_reset_done,
   input wire usb_host_regs_pkg::func_state_t functional_state_field,
   input wire logic                           frame_periodic_go,
   input wire logic                           frame_iso_go,
   input wire logic                           soft_reset_cmd,
   input wire logic                           ctrl_pending,
   input wire logic                           irq_out,
   input wire logic                           system_mgmt_irq
);
   import usb_host_regs_pkg::*;
   default clocking @(posedge clk); endclocking
   default disable iff (!arst_n);
   // A software write may override a hardware set or clear
   wire logic sw = bus_sel && bus_wr;
   // Bus request steps
   sequence rd_taken;
      ce && bus_sel && !bus_wr && !bus_ack && bus_addr == BASE_ADDR;
   endsequence
   sequence outside;
      bus_sel && (bus_addr & WINDOW_MASK) != BASE_ADDR;
   endsequence
   a_read_revision: assert property (rd_taken |=> bus_ack && bus_rdata == 32'h10)
      else $error("revision read wrong");
   a_outside_refused: assert property (outside |=> !bus_ack)
      else $error("ack outside window");
   a_ack_after_sel: assert property (bus_ack |-> $past(bus_sel) && !$past(bus_ack))
      else $error("ack without request");
   a_route_exclusive: assert property (!(irq_out && system_mgmt_irq))
      else $error("both irq paths high");
   a_ctrl_head_clear: assert property (ctrl_head_start && ce && !ctrl_fill_hw && !sw
      |=> !ctrl_pending) else $error("pending not cleared");
   a_ctrl_fill_set: assert property (ctrl_fill_hw && ce && !sw |=> ctrl_pending)
      else $error("pending not set");
   a_reset_cmd_clear: assert property (soft_reset_done && ce && !sw |=> !soft_reset_cmd)
      else $error("reset command stuck");
   a_resume_entry: assert property (functional_state_field == state_suspend && resume_detect
      && ce && !sw |=> functional_state_field == state_resume) else $error("no resume");
   a_frame_gate_hold: assert property (!(frame_begin_event && ce)
      |=> $stable(frame_periodic_go) && $stable(frame_iso_go)) else $error("gate moved");
   a_iso_in_periodic: assert property (frame_iso_go |-> frame_periodic_go)
      else $error("iso without periodic");
endmodule
bind usb_host_operational_regs usb_host_regs_sva chk (.*);
`default_nettype wire

// [verif/host_cpu_model.sv]
`timescale 1ns/1ps
`default_nettype none
// Host CPU reaching the bank as plain memory words
module host_cpu_model
(
   input  wire logic        clk,
   output logic             bus_sel,
   output logic             bus_wr,
   output logic [31:0]      bus_addr,
   output logic [31:0]      bus_wdata,
   input  wire logic [31:0] bus_rdata,
   input  wire logic        bus_ack
);
   initial {bus_sel, bus_wr, bus_addr, bus_wdata} = '0;
   // Request held through the edge that sees ack; released lines carry inverted values
   task automatic xfer(input logic w, input logic [31:0] a, d,
                       output logic [31:0] q, output logic ok);
      ok = 0;
      q = '0;
      @(negedge clk);
      {bus_sel, bus_wr, bus_addr, bus_wdata} = {1'b1, w, a, d};
      for (int n = 0; n < 4 && !ok; n++)
      begin
         @(posedge clk);
         if (bus_ack === 1'b1)
         begin
            ok = 1;
            q = bus_rdata;
         end
      end
      @(negedge clk);
      {bus_sel, bus_wr, bus_addr, bus_wdata} = {1'b0, ~w, ~a, ~d};
   endtask
endmodule
`default_nettype wire

// [verif/usb_host_operational_regs_test.sv]
`timescale 1ns/1ps
`default_nettype none
module usb_host_operational_regs_test;
   import usb_host_regs_pkg::*;
   logic clk = 0, arst_n = 0, ce = 1, bus_sel, bus_wr, bus_ack, ok;
   logic [31:0] bus_addr, bus_wdata, bus_rdata, q, shared_comm_area, periodic_cur_ptr;
   logic [31:0] ctrl_head_ptr, ctrl_cur_ptr, bulk_head_ptr, bulk_cur_ptr, done_head_ptr;
   logic [15:0] frame_counter = 16'h0000;
   logic [9:0] ev = 10'h000;
   logic [1:0] ctrl_to_bulk_ratio;
   logic bulk_proc_en, ctrl_proc_en, frame_periodic_go, frame_iso_go, soft_reset_cmd;
   logic bulk_pending, ctrl_pending, irq_out, system_mgmt_irq, resume_detect;
   logic frame_begin_event, done_written_event, overrun_event, hub_change_event;
   logic bulk_head_start, ctrl_head_start, bulk_fill_hw, ctrl_fill_hw, soft_reset_done;
   func_state_t functional_state_field;
   int err_count = 0, checked = 0, cycles = 0;
   typedef struct packed {logic [7:0] wo; logic [31:0] wd; logic [7:0] ro; logic [31:0] ex;} row_t;
   // Write offset and data, read offset, expected read
   row_t rows [14] = '{'{8'h00, 32'hffffffff, 8'h00, 32'h00000010},
      '{8'h04, 32'h000001ff, 8'h04, 32'h000001ff}, '{8'h18, 32'hffffffff, 8'h18, 32'hffffff00},
      '{8'h1c, 32'h12345678, 8'h1c, 32'h12345670}, '{8'h30, 32'hffffffff, 8'h30, 32'hfffffff0},
      '{8'h20, 32'h0000001f, 8'h20, 32'h00000010}, '{8'h24, 32'h87654321, 8'h24, 32'h87654320},
      '{8'h28, 32'h0000abcf, 8'h28, 32'h0000abc0}, '{8'h2c, 32'hfffffff8, 8'h2c, 32'hfffffff0},
      '{8'h34, 32'hffffffff, 8'h34, 32'h00000000}, '{8'h0c, 32'hffffffff, 8'h0c, 32'h00000000},
      '{8'h10, 32'hffffffff, 8'h10, 32'hc000006f}, '{8'h14, 32'h00000011, 8'h10, 32'hc000006e},
      '{8'h08, 32'h0000000e, 8'h0c, 32'h40000000}};
   // Event pulses from the list processor and frame logic
   assign {soft_reset_done, ctrl_fill_hw, bulk_fill_hw, ctrl_head_start, bulk_head_start,
           hub_change_event, overrun_event, done_written_event, frame_begin_event,
           resume_detect} = ev;
   usb_host_operational_regs dut (.*);
   host_cpu_model cpu (.*);
   initial forever #10 clk = ~clk;
   task automatic chk(input logic [31:0] got, exp);
      checked++;
      if (got !== exp)
      begin
         err_count++;
         $display("BAD %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic acc(input logic w, input logic [7:0] o, input logic [31:0] d);
      cpu.xfer(w, BASE_ADDR | {24'h0, o}, d, q, ok);
   endtask
   task automatic pulse(input logic [9:0] v, input int n);
      @(negedge clk);
      ev = v;
      repeat (n) @(negedge clk);
      ev = '0;
   endtask
   task final_report;
      $display("checked %0d err_count %0d", checked, err_count);
      if (err_count == 0 && checked > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   // Hang guard
   always @(posedge clk)
   begin
      cycles++;
      if (cycles == 3000)
      begin
         err_count++;
         final_report;
      end
   end
   // Main sequence
   initial
   begin
      repeat (8) @(negedge clk);
      arst_n = 1;
      repeat (3) @(negedge clk);
      foreach (rows[i])
      begin
         acc(1, rows[i].wo, rows[i].wd);
         acc(0, rows[i].ro, 32'h0);
         chk(q, rows[i].ex);
      end
      chk(shared_comm_area, 32'hffffff00);
      chk(periodic_cur_ptr, 32'h12345670);
      chk(ctrl_head_ptr, 32'h00000010);
      chk(ctrl_cur_ptr, 32'h87654320);
      chk(bulk_head_ptr, 32'h0000abc0);
      chk(bulk_cur_ptr, 32'hfffffff0);
      chk(done_head_ptr, 32'hfffffff0);
      chk({ctrl_to_bulk_ratio, bulk_proc_en, ctrl_proc_en, functional_state_field}, 32'h3f);
      chk({irq_out, system_mgmt_irq}, 32'h1);
      acc(1, 8'h04, 32'h000000f7);
      chk({irq_out, system_mgmt_irq}, 32'h2);
      acc(1, 8'h14, 32'h80000000);
      chk(irq_out, 0);
      acc(1, 8'h10, 32'h80000000);
      chk(irq_out, 1);
      acc(1, 8'h08, 32'h0);
      acc(1, 8'h0c, 32'h40000000);
      chk(irq_out, 0);
      frame_counter = 16'h8000;
      pulse(10'h01f, 1);
      acc(0, 8'h0c, 32'h0);
      chk(q, 32'h0000006f);
      chk({functional_state_field, frame_periodic_go, frame_iso_go}, 32'h6);
      pulse(10'h008, 4);
      acc(0, 8'h08, 32'h0);
      chk(q, 32'h00010006);
      acc(1, 8'h08, 32'h00000007);
      pulse(10'h260, 1);
      acc(0, 8'h08, 32'h0);
      chk(q, 32'h00010000);
      pulse(10'h180, 1);
      acc(0, 8'h08, 32'h0);
      chk(q, 32'h00010006);
      cpu.xfer(0, 32'h1000c000, 32'h0, q, ok);
      chk(ok, 0);
      cpu.xfer(1, BASE_ADDR | 32'h2, 32'h0, q, ok);
      chk(ok, 0);
      arst_n = 0;
      @(negedge clk);
      chk({functional_state_field, soft_reset_cmd, bulk_pending, irq_out}, 0);
      arst_n = 1;
      repeat (3) @(negedge clk);
      acc(0, 8'h04, 32'h0);
      chk(q, 0);
      acc(0, 8'h10, 32'h0);
      chk(q, 0);
      final_report;
   end
endmodule
`default_nettype wire
